// ==== dv/itc_channel_asserts.sv ====
// Checker: port-level properties of the interval timer channel
module itc_channel_asserts #(
  parameter int unsigned CNT_DIV = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Gate and waveform
  input wire logic gate_i,
  input wire logic wave_o
);
  logic [2:0] mode_ff;
  logic [15:0] low_ff;
  logic [15:0] glow_ff;
  wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Latch format writes are no-ops, so they must not move the tracked mode
  wire ctrl_w = req_w && wb_we_i && wb_adr_i == itc_pkg::ADR_CTRL && wb_sel_i[0]
    && wb_dat_i[5:4] != 2'h0;
  wire [2:0] nxt_mode = wb_dat_i[2] ? {1'b0, wb_dat_i[2:1]} : wb_dat_i[3:1];
  always_ff @(posedge clk_i) begin
    if (rst_i) mode_ff <= 3'h0;
    else if (ctrl_w) mode_ff <= nxt_mode;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || wave_o) low_ff <= 16'h0;
    else low_ff <= low_ff + 16'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || gate_i) glow_ff <= 16'h0;
    else if (glow_ff != 16'hFFFF) glow_ff <= glow_ff + 16'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req;
    req_w;
  endsequence
  ack_answer_a: assert property (wb_req |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req_w)) else $error("stray ack");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && !(wb_adr_i inside {8'h00, 8'h04,
    8'h08}) |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  mode0_low_a: assert property (ctrl_w && nxt_mode == 3'h0 |=> !wave_o)
    else $error("mode 0 select left wave high");
  mode_high_a: assert property (ctrl_w && nxt_mode != 3'h0 |=> wave_o)
    else $error("mode select left wave low");
  tc_hold_a: assert property (mode_ff == 3'h0 && wave_o && !ctrl_w |=> wave_o)
    else $error("terminal level lost");
  strobe_len_a: assert property (!wave_o && mode_ff inside {3'h2, 3'h4, 3'h5}
    |-> low_ff < CNT_DIV) else $error("strobe too long");
  gate_force_a: assert property (mode_ff inside {3'h2, 3'h3} && glow_ff > 2 * CNT_DIV
    |-> wave_o) else $error("gate low did not force wave high");
endmodule : itc_channel_asserts

// ==== dv/itc_host.sv ====
// Host model: Wishbone master issuing register cycles to the channel
module itc_host (
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic cyc_o = 1'b0,
  output logic stb_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [7:0] adr_o = 8'h00,
  output logic [3:0] sel_o = 4'h0,
  output logic [31:0] dat_o = 32'h0,
  input wire logic [31:0] dat_i,
  input wire logic ack_i
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= {24'h0, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // Released data no longer shows the last value
    dat_o <= ~dat_o;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic wr_word(input logic [15:0] n);
    wr(itc_pkg::ADR_COUNT, n[7:0]);
    wr(itc_pkg::ADR_COUNT, n[15:8]);
  endtask : wr_word
endmodule : itc_host

// ==== dv/testbench.sv ====
// Testbench: mode scenarios of the interval timer channel
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int D = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic gate_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wave_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int t;
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  itc_host u_host (.clk_i(clk_i), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
    .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i), .dat_i(wb_dat_o), .ack_i(wb_ack_o));
  itc_channel #(.CNT_DIV(D)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gate_i(gate_i),
    .wave_o(wave_o));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Cycles until wave reaches lvl, capped at lim
  task automatic wave_to(input logic lvl, input int lim, output int n);
    n = 0;
    while (wave_o !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wave_to
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    u_host.rd(8'h00, q);
    check(q, 32'h10);
    u_host.rd(8'hFC, q);
    check(q, 32'h0);
    // Mode 0, word format: gate low holds, gate high counts to terminal
    u_host.wr(8'h00, 8'h30);
    check(wave_o, 1'b0);
    u_host.rd(8'h04, q);
    check(q, 32'h0);
    u_host.wr_word(16'h0006);
    wave_to(1'b1, 40, t);
    check(t, 40);
    gate_i <= 1'b1;
    wave_to(1'b1, 100, t);
    check(t >= 5 * D && t <= 8 * D, 1);
    u_host.wr_word(16'h0003);
    wave_to(1'b0, 40, t);
    check(t, 40);
    // Lone low byte halts counting until the high byte arrives
    u_host.wr(8'h00, 8'h30);
    u_host.wr_word(16'h0014);
    repeat (10) @(posedge clk_i);
    u_host.wr(8'h04, 8'h04);
    wave_to(1'b1, 50, t);
    check(t, 50);
    u_host.wr(8'h04, 8'h00);
    wave_to(1'b1, 200, t);
    check(t >= 3 * D && t <= 6 * D, 1);
    // Mode 0, single byte: a rewrite restarts from the new value at the next count clock
    u_host.wr(8'h00, 8'h10);
    u_host.wr(8'h04, 8'h14);
    repeat (10) @(posedge clk_i);
    u_host.wr(8'h04, 8'h03);
    wave_to(1'b1, 200, t);
    check(t >= 3 * D && t <= 6 * D, 1);
    // Mode 2, n = 4, then rewrite to 6
    u_host.wr(8'h00, 8'h14);
    check(wave_o, 1'b1);
    u_host.wr(8'h04, 8'h04);
    wave_to(1'b0, 200, t);
    wave_to(1'b1, 200, t);
    check(t, D);
    wave_to(1'b0, 200, t);
    check(t, 3 * D);
    // The period running at the rewrite may still use the old count, so measure the next one
    u_host.wr(8'h04, 8'h06);
    wave_to(1'b1, 200, t);
    wave_to(1'b0, 200, t);
    wave_to(1'b1, 200, t);
    wave_to(1'b0, 200, t);
    check(t, 5 * D);
    gate_i <= 1'b0;
    repeat (3 * D) @(posedge clk_i);
    check(wave_o, 1'b1);
    gate_i <= 1'b1;
    // Mode 3, n = 5: high 3, low 2
    u_host.wr(8'h00, 8'h16);
    u_host.wr(8'h04, 8'h05);
    wave_to(1'b0, 200, t);
    wave_to(1'b1, 200, t);
    check(t, 2 * D);
    wave_to(1'b0, 200, t);
    check(t, 3 * D);
    // Mode 4, n = 3: single strobe, gate cycle restarts it
    u_host.wr(8'h00, 8'h18);
    u_host.wr(8'h04, 8'h03);
    wave_to(1'b0, 200, t);
    wave_to(1'b1, 200, t);
    check(t, D);
    wave_to(1'b0, 60, t);
    check(t, 60);
    gate_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    gate_i <= 1'b1;
    wave_to(1'b0, 60, t);
    check(t >= 3 * D && t <= 7 * D, 1);
    // Mode 5, n = 3: waits for a gate rise
    u_host.wr(8'h00, 8'h1A);
    u_host.wr(8'h04, 8'h03);
    wave_to(1'b0, 60, t);
    check(t, 60);
    gate_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    gate_i <= 1'b1;
    wave_to(1'b0, 200, t);
    wave_to(1'b1, 200, t);
    check(t, D);
    // Mode 1, n = 3: one-shot ignores gate low once running
    u_host.wr(8'h00, 8'h12);
    check(wave_o, 1'b1);
    u_host.wr(8'h04, 8'h03);
    wave_to(1'b0, 60, t);
    check(t, 60);
    gate_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    gate_i <= 1'b1;
    wave_to(1'b0, 200, t);
    gate_i <= 1'b0;
    wave_to(1'b1, 200, t);
    check(t, 3 * D);
    test_done();
  end
endmodule : testbench
bind itc_channel itc_channel_asserts #(.CNT_DIV(CNT_DIV)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .gate_i(gate_i), .wave_o(wave_o));

// ==== hw/itc_channel.sv ====
// Module: one 16-bit interval timer channel with six waveform modes and a Wishbone slave
//
// Functional notes
// R1: Least count 1 in modes 0,1,4,5 and 2 in modes 2,3; zero means 10000H.
// R2: Mode 3 count of 1 runs as 10001H.
// R3: Control write selecting mode 0 drives the waveform low at once.
// R4: Mode 0 counts after load with gate high; word format loads on high byte.
// R5: Mode 0 terminal count drives waveform high until new control word and count.
// R6: Modes 0 and 4 hold the count while gate is low, resume when high; mode 4 restarts from the programmed count instead.
// R7: Mode 0 single-byte rewrite halts counting, resumes from new value next count clock.
// R8: Mode 0 word rewrite halts on low byte, restarts after high byte.
// R9: Mode 1 sets waveform high; only a gate rising edge starts counting.
// R10: Mode 1 waveform low from count clock after trigger until terminal count.
// R11: Mode 1 ignores gate low; a new count is used only on retrigger.
// R12: Modes 2 to 5 set the waveform high on the control write.
// R13: Modes 2,3 start after the count write if gate high, else on gate rise.
// R14: Mode 2 waveform pulses low one count clock every n count clocks.
// R15: Mode 2 new count applies after the current low pulse.
// R16: Modes 2,3 gate low stops counting and forces waveform high; rise restarts.
// R17: Mode 3 square wave, odd n high (n+1)/2 and low (n-1)/2.
// R18: Mode 3 new count applies after the next waveform transition.
// R19: Mode 4 starts as mode 0; one low count clock at terminal count, once.
// R20: Mode 4 gate low then high restarts from the programmed count.
// R21: Mode 2 low pulse comes one count clock earlier than the mode 4 strobe.
// R22: Mode 5 starts and retriggers on gate rise; strobe as mode 4.
// R23: Counter decrements by two in mode 3, by one otherwise.
// R24: Control write clears the counter to zero.
// R25: Host writes low byte then high byte back to back in word format.
// R26: Gate sampled at a count clock edge; a rise acts at the following one.
module itc_channel #(
  parameter int unsigned CNT_DIV = itc_pkg::CNT_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Count control input and waveform output
  input wire logic gate_i,
  output logic wave_o
);

  localparam int unsigned DIV_W = $clog2(CNT_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CNT_DIV - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ack_ff;
  logic [31:0] dat_ff;
  logic req;
  logic wr;
  logic ctrl_wr;
  logic cnt_wr;
  logic cnt_load;
  logic [7:0] wdat;
  logic [2:0] wm;
  itc_pkg::itc_cfg_t cfg_ff;
  itc_pkg::itc_cfg_t nxt_cfg;
  itc_pkg::itc_mode_t mode;
  logic [15:0] cr_ff;
  logic [7:0] lo_ff;
  logic msb_next_ff;
  logic [DIV_W-1:0] div_ff;
  logic tick_ff;
  logic gate_s_ff;
  logic trig_ff;
  logic [16:0] cnt_ff;
  logic wave_ff;
  logic run_ff;
  logic pend_ff;
  logic hold_ff;
  logic loaded_ff;
  logic [16:0] eff_cnt;
  logic [16:0] ph_hi;
  logic [16:0] ph_lo;
  logic start23;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];
  // A latch command leaves mode and counter untouched and has no other effect
  assign ctrl_wr = wr & (wb_adr_i == itc_pkg::ADR_CTRL) &
                   (wdat[itc_pkg::CTRL_FMT_LSB +: 2] != itc_pkg::FMT_LATCH);
  assign cnt_wr = wr & (wb_adr_i == itc_pkg::ADR_COUNT);

  // Mode 2 and 3 ignore the top mode bit
  assign wm = wdat[itc_pkg::CTRL_MODE_LSB +: 3];
  assign nxt_cfg.byte_access_format = itc_pkg::itc_fmt_t'(wdat[itc_pkg::CTRL_FMT_LSB +: 2]);
  assign nxt_cfg.operating_mode_field = itc_pkg::itc_mode_t'(wm[1] ? {1'b0, wm[1:0]} : wm);
  assign mode = cfg_ff.operating_mode_field;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h00000000;
    end else if (req & ~wb_we_i) begin
      unique case (wb_adr_i)
        itc_pkg::ADR_CTRL: dat_ff <= {26'h0000000, cfg_ff, 1'b0};
        itc_pkg::ADR_COUNT: dat_ff <= {16'h0000, cnt_ff[15:0]};
        itc_pkg::ADR_STATUS: dat_ff <= {27'h0000000, loaded_ff, gate_s_ff, pend_ff,
                                        run_ff, wave_ff};
        default: dat_ff <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ----------------------------------------------------------------
  // Configuration and count staging
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= itc_pkg::CFG_RST;
    end else if (ctrl_wr) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Count is complete on a single byte, or on the high byte of a word
  assign cnt_load = cnt_wr & ((cfg_ff.byte_access_format != itc_pkg::FMT_WORD) | msb_next_ff); // R4

  // The low byte of a word is staged apart so a reload mid-write uses the old count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr_ff <= 16'h0000;
      lo_ff <= 8'h00;
      msb_next_ff <= 1'b0;
    end else if (ctrl_wr) begin
      msb_next_ff <= 1'b0;
    end else if (cnt_wr) begin
      unique case (cfg_ff.byte_access_format)
        itc_pkg::FMT_LSB: cr_ff <= {8'h00, wdat};
        itc_pkg::FMT_MSB: cr_ff <= {wdat, 8'h00};
        itc_pkg::FMT_WORD: begin
          if (msb_next_ff) begin
            cr_ff <= {wdat, lo_ff}; // R25
            msb_next_ff <= 1'b0;
          end else begin
            lo_ff <= wdat;
            msb_next_ff <= 1'b1;
          end
        end
        default: cr_ff <= cr_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Count clock enable and gate sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= (div_ff == DIV_LAST) ? '0 : div_ff + DIV_W'(1);
      tick_ff <= (div_ff == DIV_LAST);
    end
  end

  // A rise seen at one count clock is acted on at the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_s_ff <= 1'b0;
      trig_ff <= 1'b0;
    end else if (tick_ff) begin
      gate_s_ff <= gate_i; // R26
      trig_ff <= gate_i & ~gate_s_ff; // R26
    end
  end

  // ----------------------------------------------------------------
  // Effective count and square wave half periods
  // ----------------------------------------------------------------
  always_comb begin
    if (cr_ff == 16'h0000) begin
      eff_cnt = itc_pkg::FULL_COUNT; // R1
    end else if (mode == itc_pkg::MODE_SQUARE && cr_ff == 16'h0001) begin
      eff_cnt = itc_pkg::FULL_SQUARE; // R2
    end else begin
      eff_cnt = {1'b0, cr_ff};
    end
  end

  // Counting by two: the high half gets the extra clock of an odd count
  assign ph_hi = eff_cnt + {16'h0000, eff_cnt[0]}; // R17
  assign ph_lo = eff_cnt - {16'h0000, eff_cnt[0]}; // R17

  assign start23 = trig_ff | (pend_ff & ~run_ff); // R13

  // ----------------------------------------------------------------
  // Counter and waveform
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 17'h00000;
      wave_ff <= itc_pkg::WAVE_RST;
      run_ff <= 1'b0;
      pend_ff <= 1'b0;
      hold_ff <= 1'b0;
      loaded_ff <= 1'b0;
    end else if (ctrl_wr) begin
      cnt_ff <= 17'h00000; // R24
      wave_ff <= (nxt_cfg.operating_mode_field != itc_pkg::MODE_TC); // R3 R5 R9 R12
      run_ff <= 1'b0;
      pend_ff <= 1'b0;
      hold_ff <= 1'b0;
      loaded_ff <= 1'b0;
    end else begin
      if (tick_ff) begin
        unique case (mode)
          itc_pkg::MODE_TC, itc_pkg::MODE_SWSTROBE: begin
            // End of the one-clock strobe
            if (mode == itc_pkg::MODE_SWSTROBE && !wave_ff) begin
              wave_ff <= 1'b1; // R19
            end
            if (pend_ff) begin
              cnt_ff <= eff_cnt; // R4 R7 R8
              run_ff <= 1'b1;
              pend_ff <= 1'b0;
              hold_ff <= 1'b0;
            end else if (mode == itc_pkg::MODE_SWSTROBE && trig_ff && loaded_ff) begin
              cnt_ff <= eff_cnt; // R20
              run_ff <= 1'b1;
            end else if (run_ff && gate_s_ff && !hold_ff) begin // R6
              cnt_ff <= cnt_ff - itc_pkg::CNT_ONE; // R23
              if (cnt_ff == itc_pkg::CNT_ONE) begin
                run_ff <= 1'b0;
                wave_ff <= (mode == itc_pkg::MODE_TC); // R5 R19 R21
              end
            end
          end
          itc_pkg::MODE_ONESHOT, itc_pkg::MODE_HWSTROBE: begin
            pend_ff <= 1'b0;
            if (mode == itc_pkg::MODE_HWSTROBE && !wave_ff) begin
              wave_ff <= 1'b1; // R22
            end
            // Gate level is ignored once the shot runs
            if (trig_ff && loaded_ff) begin
              cnt_ff <= eff_cnt; // R9 R11 R22
              run_ff <= 1'b1;
              if (mode == itc_pkg::MODE_ONESHOT) begin
                wave_ff <= 1'b0; // R10
              end
            end else if (run_ff) begin
              cnt_ff <= cnt_ff - itc_pkg::CNT_ONE; // R23
              if (cnt_ff == itc_pkg::CNT_ONE) begin
                run_ff <= 1'b0;
                wave_ff <= (mode == itc_pkg::MODE_ONESHOT); // R10 R22
              end
            end
          end
          itc_pkg::MODE_RATE: begin
            if (!gate_s_ff) begin
              wave_ff <= 1'b1; // R16
              run_ff <= 1'b0;
            end else if (start23 && loaded_ff) begin
              cnt_ff <= eff_cnt; // R13 R16
              run_ff <= 1'b1;
              pend_ff <= 1'b0;
              wave_ff <= 1'b1;
            end else if (run_ff) begin
              pend_ff <= 1'b0;
              if (cnt_ff == itc_pkg::CNT_TWO) begin
                cnt_ff <= itc_pkg::CNT_ONE;
                wave_ff <= 1'b0; // R14 R21
              end else if (cnt_ff == itc_pkg::CNT_ONE) begin
                cnt_ff <= eff_cnt; // R14 R15
                wave_ff <= 1'b1;
              end else begin
                cnt_ff <= cnt_ff - itc_pkg::CNT_ONE; // R23
              end
            end
          end
          itc_pkg::MODE_SQUARE: begin
            if (!gate_s_ff) begin
              wave_ff <= 1'b1; // R16
              run_ff <= 1'b0;
            end else if (start23 && loaded_ff) begin
              cnt_ff <= ph_hi; // R13 R16
              run_ff <= 1'b1;
              pend_ff <= 1'b0;
              wave_ff <= 1'b1;
            end else if (run_ff) begin
              pend_ff <= 1'b0;
              if (cnt_ff == itc_pkg::CNT_TWO) begin
                wave_ff <= ~wave_ff; // R17
                cnt_ff <= wave_ff ? ph_lo : ph_hi; // R18
              end else begin
                cnt_ff <= cnt_ff - itc_pkg::CNT_TWO; // R23
              end
            end
          end
          default: begin
            run_ff <= 1'b0;
          end
        endcase
      end
      // Bus writes come last so a count written on a count clock is not lost
      if (cnt_wr && mode == itc_pkg::MODE_TC) begin
        hold_ff <= 1'b1; // R7 R8
      end
      if (cnt_load) begin
        pend_ff <= 1'b1;
        loaded_ff <= 1'b1;
      end
    end
  end

  assign wave_o = wave_ff;

endmodule : itc_channel

// ==== hw/itc_pkg.sv ====
// Package: constants, register map and types of the interval timer channel
package itc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned CNT_CLK_NS = 1000;
  // Count clock divider, rounded up so the count clock never runs fast
  localparam int unsigned CNT_DIV = (CNT_CLK_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_COUNT = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;

  // Control register field positions
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_FMT_LSB = 4;

  // Status register bit positions
  localparam int unsigned ST_WAVE = 0;
  localparam int unsigned ST_RUN = 1;
  localparam int unsigned ST_PEND = 2;
  localparam int unsigned ST_GATE = 3;
  localparam int unsigned ST_LOADED = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_TC = 3'b000,
    MODE_ONESHOT = 3'b001,
    MODE_RATE = 3'b010,
    MODE_SQUARE = 3'b011,
    MODE_SWSTROBE = 3'b100,
    MODE_HWSTROBE = 3'b101
  } itc_mode_t;

  typedef enum logic [1:0] {
    FMT_LATCH = 2'b00,
    FMT_LSB = 2'b01,
    FMT_MSB = 2'b10,
    FMT_WORD = 2'b11
  } itc_fmt_t;

  typedef struct packed {
    itc_fmt_t byte_access_format;
    itc_mode_t operating_mode_field;
  } itc_cfg_t;

  // ----------------------------------------------------------------
  // Reset values and special counts
  // ----------------------------------------------------------------
  localparam itc_cfg_t CFG_RST = '{byte_access_format: FMT_LSB, operating_mode_field: MODE_TC};
  localparam logic WAVE_RST = 1'b0;
  localparam logic [16:0] FULL_COUNT = 17'h10000;
  localparam logic [16:0] FULL_SQUARE = 17'h10001;
  localparam logic [16:0] CNT_ONE = 17'h00001;
  localparam logic [16:0] CNT_TWO = 17'h00002;

endpackage : itc_pkg
